/* csc_pkg.sv */
// csc_pkg: types and constants for the call/return/flag execution unit
// assumes one 20 MHz clock; one cpu state is one clock cycle
package csc_pkg;

  // condition flag positions inside the condition_code_register
  localparam int CCR_H = 5;
  localparam int CCR_N = 3;
  localparam int CCR_Z = 2;
  localparam int CCR_V = 1;
  localparam int CCR_C = 0;

  // execution lengths in cpu states
  localparam logic [10:0] LEN_CALL_REG = 11'h006;
  localparam logic [10:0] LEN_CALL_ABS = 11'h008;
  localparam logic [10:0] LEN_CALL_IND = 11'h008;
  localparam logic [10:0] LEN_SUB_RET  = 11'h008;
  localparam logic [10:0] LEN_EXC_RET  = 11'h00a;
  localparam logic [10:0] LEN_SHORT    = 11'h002;
  localparam logic [10:0] LEN_DIV      = 11'h00e;
  localparam logic [10:0] LEN_REP_BASE = 11'h009;
  localparam int          REP_SHIFT    = 2; // four states per repeat

  // state steps at which memory work happens
  localparam logic [10:0] STEP_ISSUE   = 11'h000;
  localparam logic [10:0] STEP_FIRST   = 11'h002;
  localparam logic [10:0] STEP_PUSH    = 11'h003;
  localparam logic [10:0] STEP_SECOND  = 11'h004;

  localparam logic [15:0] STACK_STEP   = 16'h0002;
  localparam logic [15:0] PC_STEP      = 16'h0002;
  localparam logic [7:0]  PAGE_ZERO    = 8'h00;
  localparam logic [3:0]  BCD_MAX      = 4'h9;
  localparam logic [7:0]  BCD_LOW_ADJ  = 8'h06;
  localparam logic [7:0]  BCD_HIGH_ADJ = 8'h60;
  localparam logic [7:0]  BCD_LIMIT    = 8'h99;

  typedef enum logic [4:0] {
    OP_NO_OP          = 5'h00,
    OP_CALL_REG       = 5'h01,
    OP_CALL_ABS       = 5'h02,
    OP_CALL_IND       = 5'h03,
    OP_SUB_RET        = 5'h04,
    OP_EXC_RET        = 5'h05,
    OP_SLEEP          = 5'h06,
    OP_FLAGS_LOAD_IMM = 5'h07,
    OP_FLAGS_LOAD_REG = 5'h08,
    OP_FLAGS_STORE    = 5'h09,
    OP_FLAGS_AND      = 5'h0a,
    OP_FLAGS_OR       = 5'h0b,
    OP_FLAGS_XOR      = 5'h0c,
    OP_ADD_WORD       = 5'h0d,
    OP_SUB_WORD       = 5'h0e,
    OP_ADD_CARRY      = 5'h0f,
    OP_SUB_CARRY      = 5'h10,
    OP_DEC_ADJ        = 5'h11,
    OP_DIVIDE         = 5'h12,
    OP_REPEAT         = 5'h13
  } csc_op_t;

  typedef enum logic [0:0] {
    ST_IDLE = 1'b0,
    ST_RUN  = 1'b1
  } csc_state_t;

  // one instruction handed over by the decoder
  typedef struct packed {
    csc_op_t     op;
    logic [15:0] imm;     // immediate or absolute address
    logic [15:0] reg_val; // general register operand
    logic [15:0] opa;     // alu operand a / dividend
    logic [15:0] opb;     // alu operand b / divisor in low byte
    logic [7:0]  count;   // count_reg_low_byte
    logic [15:0] pc;
    logic [15:0] sp;
    logic [7:0]  ccr;
  } csc_req_t;

  // stack / program memory request, read data valid one cycle later
  typedef struct packed {
    logic        req;
    logic        we;
    logic [15:0] addr;
    logic [15:0] wdata;
  } csc_mem_t;

endpackage

/* csc_exec.sv */
// csc_exec: executes calls, returns, sleep, condition_code_register ops
// assumes decoder holds req_i stable while start_i is high and busy_o low;
// memory answers a read in the cycle after mem_o.req
`timescale 1ns/1ps
// Behaviour
// - call pushes pc, sp minus two, jumps
// - return pops pc, sp plus two, 8 states
// - exception return pops flags then pc, 10 states
// - sleep entered after 2 states, flags kept
// - flags AND immediate, 2 states
// - flags OR immediate, 2 states
// - flags XOR immediate, 2 states
// - half flag from carry out bit 11
// - zero flag kept only on zero result
// - decimal adjust carry sets carry flag
// - repeat takes 4n+9 states
// - divide negative divisor sets N
// - divide zero divisor sets Z
module csc_exec
  import csc_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rstn,
  input  wire logic        start_i,
  input  wire csc_req_t    req_i,
  input  wire logic [15:0] mem_rdata_i,
  input  wire logic        wake_i,
  output csc_mem_t         mem_o,
  output logic             busy_o,
  output logic             done_o,
  output logic [15:0]      pc_o,
  output logic [15:0]      sp_o,
  output logic [7:0]       ccr_o,
  output logic [15:0]      rd_data_o,
  output logic             rd_we_o,
  output logic             sleep_o
);

  typedef struct packed {
    csc_state_t  st;
    csc_req_t    q;      // captured instruction
    logic [10:0] cnt;
    logic [10:0] len;
    logic [15:0] pc;
    logic [15:0] sp;
    logic [7:0]  ccr;
    logic [15:0] tgt;    // jump target or popped word
    csc_mem_t    mem;
    logic [15:0] rd;
    logic        rd_we;
    logic        done;
    logic        sleep;
  } csc_regs_t;

  csc_regs_t r_r;
  csc_regs_t r_nxt;
  logic      acc;

  // execution length of one instruction in states
  function automatic logic [10:0] op_len(input csc_op_t o,
                                         input logic [7:0] n);
    case (o)
      OP_CALL_REG: op_len = LEN_CALL_REG;
      OP_CALL_ABS: op_len = LEN_CALL_ABS;
      OP_CALL_IND: op_len = LEN_CALL_IND;
      OP_SUB_RET:  op_len = LEN_SUB_RET;
      OP_EXC_RET:  op_len = LEN_EXC_RET;
      OP_DIVIDE:   op_len = LEN_DIV;
      OP_REPEAT:   op_len = ({3'h0, n} << REP_SHIFT) + LEN_REP_BASE;
      default:     op_len = LEN_SHORT;
    endcase
  endfunction

  // read request to memory
  function automatic csc_mem_t mem_rd(input logic [15:0] a);
    mem_rd = '{req: 1'b1, we: 1'b0, addr: a, wdata: 16'h0000};
  endfunction

  assign acc = start_i && (r_r.st == ST_IDLE);

  // next-state logic for the whole unit
  always_comb
  begin
    logic [7:0]  f;
    logic [12:0] h12;
    logic [16:0] w;
    logic [8:0]  b;
    logic        dc;
    logic [7:0]  adj;
    csc_req_t    q;
    f     = r_r.ccr;
    h12   = 13'h0000;
    w     = 17'h0_0000;
    b     = 9'h000;
    dc    = 1'b0;
    adj   = 8'h00;
    q     = r_r.q;
    r_nxt = r_r;
    r_nxt.mem   = '0;
    r_nxt.rd_we = 1'b0;
    r_nxt.done  = 1'b0;
    if (wake_i)
    begin
      r_nxt.sleep = 1'b0;
    end
    case (r_r.st)
      ST_IDLE:
      begin
        if (acc)
        begin
          r_nxt.st  = ST_RUN;
          r_nxt.q   = req_i;
          r_nxt.cnt = 11'h000;
          r_nxt.len = op_len(req_i.op, req_i.count);
          r_nxt.pc  = req_i.pc;
          r_nxt.sp  = req_i.sp;
          r_nxt.ccr = req_i.ccr;
          r_nxt.tgt = (req_i.op == OP_CALL_REG) ? req_i.reg_val
                                                : req_i.imm;
        end
      end
      ST_RUN:
      begin
        r_nxt.cnt = r_r.cnt + 11'h001;
        // stack and vector traffic
        case (q.op)
          OP_CALL_REG, OP_CALL_ABS, OP_CALL_IND:
          begin
            if (q.op == OP_CALL_IND && r_r.cnt == STEP_ISSUE)
            begin
              r_nxt.mem = mem_rd({PAGE_ZERO, q.imm[7:0]});
            end
            if (q.op == OP_CALL_IND && r_r.cnt == STEP_FIRST)
            begin
              r_nxt.tgt = mem_rdata_i;
            end
            if (r_r.cnt == STEP_PUSH)
            begin
              r_nxt.sp  = r_r.sp - STACK_STEP;
              r_nxt.mem = '{req: 1'b1, we: 1'b1,
                            addr: r_r.sp - STACK_STEP, wdata: r_r.pc};
            end
          end
          OP_SUB_RET, OP_EXC_RET:
          begin
            if (r_r.cnt == STEP_ISSUE)
            begin
              r_nxt.mem = mem_rd(r_r.sp);
            end
            if (r_r.cnt == STEP_FIRST)
            begin
              r_nxt.sp = r_r.sp + STACK_STEP;
              if (q.op == OP_EXC_RET)
              begin
                r_nxt.ccr = mem_rdata_i[15:8];
                r_nxt.mem = mem_rd(r_r.sp + STACK_STEP);
              end
              else
              begin
                r_nxt.tgt = mem_rdata_i;
              end
            end
            if (q.op == OP_EXC_RET && r_r.cnt == STEP_SECOND)
            begin
              r_nxt.tgt = mem_rdata_i;
              r_nxt.sp  = r_r.sp + STACK_STEP;
            end
          end
          default:
          begin
          end
        endcase
        // last state: commit results
        if (r_r.cnt == r_r.len - 11'h001)
        begin
          r_nxt.st   = ST_IDLE;
          r_nxt.done = 1'b1;
          case (q.op)
            OP_NO_OP:    r_nxt.pc = r_r.pc + PC_STEP;
            OP_CALL_REG, OP_CALL_ABS, OP_CALL_IND, OP_SUB_RET, OP_EXC_RET:
              r_nxt.pc = r_r.tgt;
            OP_SLEEP:    r_nxt.sleep = 1'b1;
            OP_FLAGS_LOAD_IMM: f = q.imm[7:0];
            OP_FLAGS_LOAD_REG: f = q.reg_val[7:0];
            OP_FLAGS_STORE:
            begin
              r_nxt.rd    = {8'h00, r_r.ccr};
              r_nxt.rd_we = 1'b1;
            end
            OP_FLAGS_AND: f = r_r.ccr & q.imm[7:0];
            OP_FLAGS_OR:  f = r_r.ccr | q.imm[7:0];
            OP_FLAGS_XOR: f = r_r.ccr ^ q.imm[7:0];
            OP_ADD_WORD, OP_SUB_WORD:
            begin
              if (q.op == OP_ADD_WORD)
              begin
                w   = {1'b0, q.opa} + {1'b0, q.opb};
                h12 = {1'b0, q.opa[11:0]} + {1'b0, q.opb[11:0]};
              end
              else
              begin
                w   = {1'b0, q.opa} - {1'b0, q.opb};
                h12 = {1'b0, q.opa[11:0]} - {1'b0, q.opb[11:0]};
              end
              f[CCR_H] = h12[12];
              f[CCR_N] = w[15];
              f[CCR_Z] = (w[15:0] == 16'h0000);
              f[CCR_C] = w[16];
              r_nxt.rd    = w[15:0];
              r_nxt.rd_we = 1'b1;
            end
            OP_ADD_CARRY, OP_SUB_CARRY:
            begin
              if (q.op == OP_ADD_CARRY)
              begin
                b = {1'b0, q.opa[7:0]} + {1'b0, q.opb[7:0]}
                    + {8'h00, r_r.ccr[CCR_C]};
              end
              else
              begin
                b = {1'b0, q.opa[7:0]} - {1'b0, q.opb[7:0]}
                    - {8'h00, r_r.ccr[CCR_C]};
              end
              f[CCR_N] = b[7];
              f[CCR_Z] = r_r.ccr[CCR_Z] && (b[7:0] == 8'h00);
              f[CCR_C] = b[8];
              r_nxt.rd    = {8'h00, b[7:0]};
              r_nxt.rd_we = 1'b1;
            end
            OP_DEC_ADJ:
            begin
              dc  = r_r.ccr[CCR_C] || (q.opa[7:0] > BCD_LIMIT);
              adj = ((r_r.ccr[CCR_H] || q.opa[3:0] > BCD_MAX)
                     ? BCD_LOW_ADJ : 8'h00) | (dc ? BCD_HIGH_ADJ : 8'h00);
              b   = {1'b0, q.opa[7:0]} + {1'b0, adj};
              f[CCR_C] = dc;
              f[CCR_N] = b[7];
              f[CCR_Z] = (b[7:0] == 8'h00);
              r_nxt.rd    = {8'h00, b[7:0]};
              r_nxt.rd_we = 1'b1;
            end
            OP_DIVIDE:
            begin
              f[CCR_N] = q.opb[7];
              f[CCR_Z] = (q.opb[7:0] == 8'h00);
              if (q.opb[7:0] != 8'h00)
              begin
                r_nxt.rd    = {8'(q.opa % {8'h00, q.opb[7:0]}),
                               8'(q.opa / {8'h00, q.opb[7:0]})};
                r_nxt.rd_we = 1'b1;
              end
            end
            default:
            begin
            end
          endcase
          r_nxt.ccr = f;
        end
      end
      default: r_nxt.st = ST_IDLE;
    endcase
  end

  // state register
  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      r_r <= '0;
    end
    else
    begin
      r_r <= r_nxt;
    end
  end

  assign mem_o     = r_r.mem;
  assign busy_o    = (r_r.st != ST_IDLE);
  assign done_o    = r_r.done;
  assign pc_o      = r_r.pc;
  assign sp_o      = r_r.sp;
  assign ccr_o     = r_r.ccr;
  assign rd_data_o = r_r.rd;
  assign rd_we_o   = r_r.rd_we;
  assign sleep_o   = r_r.sleep;

  // cycles since acceptance, read only by the checks
  logic [10:0] elapsed_r;
  always_ff @(posedge clk)
  begin
    if (!rstn || acc)
    begin
      elapsed_r <= 11'h000;
    end
    else if (busy_o)
    begin
      elapsed_r <= elapsed_r + 11'h001;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);

  sequence s_acc(csc_op_t o);
    acc && req_i.op == o;
  endsequence

  sequence s_push(logic [15:0] s, logic [15:0] p);
    mem_o.req && mem_o.we && mem_o.addr == s - STACK_STEP
      && mem_o.wdata == p;
  endsequence

  call_reg_a: assert property (s_acc(OP_CALL_REG) |-> ##5
    s_push($past(req_i.sp, 5), $past(req_i.pc, 5)) ##2
    (done_o && pc_o == $past(req_i.reg_val, 7)))
    else $error("register call push or target wrong");
  call_ind_a: assert property (s_acc(OP_CALL_IND) |-> ##2
    (mem_o.req && !mem_o.we) ##3 s_push($past(req_i.sp, 5),
    $past(req_i.pc, 5)) ##4 done_o)
    else $error("indirect call sequence wrong");
  sub_ret_a: assert property (s_acc(OP_SUB_RET) |-> ##1 !done_o[*8]
    ##1 (done_o && sp_o == $past(req_i.sp, 9) + STACK_STEP
    && ccr_o == $past(req_i.ccr, 9)))
    else $error("subroutine return timing or stack wrong");
  exc_ret_a: assert property (s_acc(OP_EXC_RET) |-> ##11
    (done_o && sp_o == $past(req_i.sp, 11) + STACK_STEP + STACK_STEP))
    else $error("exception return timing or stack wrong");
  sleep_entry_a: assert property (s_acc(OP_SLEEP) |-> ##3
    (done_o && sleep_o && ccr_o == $past(req_i.ccr, 3)))
    else $error("sleep entry wrong");
  flags_and_a: assert property (s_acc(OP_FLAGS_AND) |-> ##3
    ccr_o == $past(req_i.ccr & req_i.imm[7:0], 3))
    else $error("flags and result wrong");
  flags_or_a: assert property (s_acc(OP_FLAGS_OR) |-> ##3
    ccr_o == $past(req_i.ccr | req_i.imm[7:0], 3))
    else $error("flags or result wrong");
  flags_xor_a: assert property (s_acc(OP_FLAGS_XOR) |-> ##3
    ccr_o == $past(req_i.ccr ^ req_i.imm[7:0], 3))
    else $error("flags xor result wrong");
  half_carry_a: assert property (s_acc(OP_ADD_WORD) |-> ##3
    ccr_o[CCR_H] == $past(13'(req_i.opa[11:0]) + 13'(req_i.opb[11:0]),
    3) >> 12)
    else $error("half flag wrong");
  zero_keep_a: assert property (s_acc(OP_SUB_CARRY)
    && !req_i.ccr[CCR_Z] |-> ##3 !ccr_o[CCR_Z])
    else $error("zero flag not kept clear");
  dec_carry_a: assert property (s_acc(OP_DEC_ADJ)
    && req_i.opa[7:0] > BCD_LIMIT |-> ##3 ccr_o[CCR_C])
    else $error("decimal adjust carry lost");
  repeat_len_a: assert property (done_o && $past(r_r.q.op) == OP_REPEAT
    |-> elapsed_r == ({3'h0, $past(r_r.q.count)} << REP_SHIFT)
    + LEN_REP_BASE)
    else $error("repeat length wrong");
  div_flags_a: assert property (s_acc(OP_DIVIDE) |-> ##15
    (done_o && ccr_o[CCR_N] == $past(req_i.opb[7], 15)
    && ccr_o[CCR_Z] == ($past(req_i.opb[7:0], 15) == 8'h00)))
    else $error("divide flags wrong");
  flags_store_a: assert property (s_acc(OP_FLAGS_STORE) |-> ##3
    (rd_we_o && rd_data_o[7:0] == $past(req_i.ccr, 3)
    && ccr_o == $past(req_i.ccr, 3)))
    else $error("flags store wrong");

endmodule // csc_exec

/* csc_mem_model.sv */
// csc_mem_model: program memory and stack word memory beside csc_exec
// assumes one clock; a read answers in the cycle after the request
`timescale 1ns/1ps
module csc_mem_model
  import csc_pkg::*;
(
  input  wire logic     clk,
  input  wire csc_mem_t mem_i,
  output logic [15:0]   rdata_o
);
  logic [15:0] mem [0:255];

  initial rdata_o = 16'h0000;

  // word store; read data is valid for one cycle only, then scrambled
  always @(posedge clk)
  begin
    if (mem_i.req && mem_i.we)
      mem[mem_i.addr[8:1]] <= mem_i.wdata;
    if (mem_i.req && !mem_i.we)
      rdata_o <= mem[mem_i.addr[8:1]];
    else
      rdata_o <= ~rdata_o; // stale word must not be mistaken for data
  end
endmodule // csc_mem_model

/* test_cpu_subroutine_ccr_instr.sv */
// test_cpu_subroutine_ccr_instr: self-checking bench for csc_exec
// assumes csc_pkg and csc_mem_model; inputs change on the falling edge
`timescale 1ns/1ps
module test_cpu_subroutine_ccr_instr;
  import csc_pkg::*;
  logic        clk;
  logic        rstn;
  logic        start_i;
  logic        wake_i;
  csc_req_t    req_i;
  csc_req_t    rq;
  csc_mem_t    mem_o;
  logic [15:0] rdata;
  logic        busy_o;
  logic        done_o;
  logic [15:0] pc_o;
  logic [15:0] sp_o;
  logic [7:0]  ccr_o;
  logic [15:0] rd_data_o;
  logic        rd_we_o;
  logic        sleep_o;
  logic [15:0] n_cyc;
  int          n_fail;
  int          check_count;
  int          cyc;

  csc_exec csc_exec_inst (.clk(clk), .rstn(rstn), .start_i(start_i),
    .req_i(req_i), .mem_rdata_i(rdata), .wake_i(wake_i), .mem_o(mem_o),
    .busy_o(busy_o), .done_o(done_o), .pc_o(pc_o), .sp_o(sp_o),
    .ccr_o(ccr_o), .rd_data_o(rd_data_o), .rd_we_o(rd_we_o),
    .sleep_o(sleep_o));

  csc_mem_model csc_mem_model_inst (.clk(clk), .mem_i(mem_o),
    .rdata_o(rdata));

  // 50 ns clock
  initial
  begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task summarize;
    $display("checks %0d failures %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  // issue rq, count states until done; returns in the done cycle
  task automatic go;
    @(negedge clk);
    start_i = 1'b1;
    req_i = rq;
    @(negedge clk);
    start_i = 1'b0;
    n_cyc = 16'h0000;
    do
    begin
      @(posedge clk);
      #1;
      n_cyc++;
    end while (done_o !== 1'b1 && n_cyc < 16'h0064);
  endtask

  // calls of all three kinds, then return onto the pushed word
  task automatic t_call_ret;
    rq = '0;
    rq.op = OP_CALL_REG;
    rq.pc = 16'h1234;
    rq.sp = 16'h0100;
    rq.reg_val = 16'h4000;
    rq.ccr = 8'ha5;
    go;
    chk(n_cyc, 16'h0006);
    chk(sp_o, 16'h00fe);
    chk(pc_o, 16'h4000);
    chk(csc_mem_model_inst.mem[8'h7f], 16'h1234);
    rq.op = OP_CALL_ABS;
    rq.imm = 16'h5678;
    go;
    chk(n_cyc, 16'h0008);
    chk(pc_o, 16'h5678);
    csc_mem_model_inst.mem[8'h10] = 16'h6000;
    rq.op = OP_CALL_IND;
    rq.imm = 16'h0020;
    go;
    chk(n_cyc, 16'h0008);
    chk(pc_o, 16'h6000);
    chk(sp_o, 16'h00fe);
    rq.op = OP_SUB_RET;
    rq.sp = 16'h00fe;
    rq.pc = 16'h0000; // so a kept pc cannot pass for the popped one
    go;
    chk(n_cyc, 16'h0008);
    chk(pc_o, 16'h1234);
    chk(sp_o, 16'h0100);
    chk(ccr_o, 8'ha5);
  endtask

  // exception return pops flags word then pc word
  task automatic t_exc;
    csc_mem_model_inst.mem[8'h78] = 16'h5a00;
    csc_mem_model_inst.mem[8'h79] = 16'h2468;
    rq = '0;
    rq.op = OP_EXC_RET;
    rq.sp = 16'h00f0;
    rq.ccr = 8'hff;
    go;
    chk(n_cyc, 16'h000a);
    chk(ccr_o, 8'h5a);
    chk(pc_o, 16'h2468);
    chk(sp_o, 16'h00f4);
  endtask

  // reset in mid-instruction returns busy, done and pc to zero
  task automatic t_reset;
    rq = '0;
    rq.op = OP_DIVIDE;
    rq.pc = 16'h0abc;
    @(negedge clk);
    start_i = 1'b1;
    req_i = rq;
    @(negedge clk);
    start_i = 1'b0;
    rstn = 1'b0;
    @(negedge clk);
    rstn = 1'b1;
    chk(busy_o, 1'b0);
    chk(done_o, 1'b0);
    chk(pc_o, 16'h0000);
  endtask

  // sleep entry, flags untouched, then wake
  task automatic t_sleep;
    rq = '0;
    rq.op = OP_SLEEP;
    rq.ccr = 8'h96;
    go;
    chk(n_cyc, 16'h0002);
    chk(sleep_o, 1'b1);
    chk(ccr_o, 8'h96);
    @(negedge clk);
    wake_i = 1'b1;
    @(negedge clk);
    wake_i = 1'b0;
    chk(sleep_o, 1'b0);
    // no_operation steps pc by two in two states
    rq.op = OP_NO_OP;
    rq.pc = 16'h0100;
    go;
    chk(n_cyc, 16'h0002);
    chk(pc_o, 16'h0102);
    chk(busy_o, 1'b0);
  endtask

  // every flag operation from one starting value, back to back
  task automatic t_flags;
    csc_op_t    fop [6];
    logic [7:0] fexp [6];
    fop = '{OP_FLAGS_AND, OP_FLAGS_OR, OP_FLAGS_XOR, OP_FLAGS_LOAD_IMM,
            OP_FLAGS_LOAD_REG, OP_FLAGS_STORE};
    fexp = '{8'hc3 & 8'h5a, 8'hc3 | 8'h5a, 8'hc3 ^ 8'h5a, 8'h5a, 8'h3c,
             8'hc3};
    rq = '0;
    rq.ccr = 8'hc3;
    rq.imm = 16'h005a;
    rq.reg_val = 16'h003c;
    for (int i = 0; i < 6; i++)
    begin
      rq.op = fop[i];
      go;
      chk(n_cyc, 16'h0002);
      chk(ccr_o, fexp[i]);
    end
    chk(rd_data_o[7:0], 8'hc3);
    chk(rd_we_o, 1'b1);
  endtask

  // one arithmetic op with operands and starting flags
  task automatic alu(input csc_op_t op, input logic [15:0] a,
                     input logic [15:0] b, input logic [7:0] c);
    rq = '0;
    rq.op = op;
    rq.opa = a;
    rq.opb = b;
    rq.ccr = c;
    go;
  endtask

  // half carry, sticky zero, decimal carry, divide flags, repeat length
  task automatic t_alu;
    alu(OP_ADD_WORD, 16'h0800, 16'h0800, 8'h00);
    chk(ccr_o[CCR_H], 1'b1);
    alu(OP_ADD_WORD, 16'h0001, 16'h0001, 8'h20);
    chk(ccr_o[CCR_H], 1'b0);
    alu(OP_SUB_WORD, 16'h1000, 16'h0001, 8'h00);
    chk(ccr_o[CCR_H], 1'b1);
    alu(OP_ADD_CARRY, 16'h0000, 16'h0000, 8'h04);
    chk(ccr_o[CCR_Z], 1'b1);
    alu(OP_ADD_CARRY, 16'h0000, 16'h0000, 8'h00);
    chk(ccr_o[CCR_Z], 1'b0);
    alu(OP_ADD_CARRY, 16'h0001, 16'h0000, 8'h04);
    chk(ccr_o[CCR_Z], 1'b0);
    alu(OP_SUB_CARRY, 16'h0005, 16'h0005, 8'h00);
    chk(ccr_o[CCR_Z], 1'b0);
    alu(OP_SUB_CARRY, 16'h0005, 16'h0004, 8'h05);
    chk(ccr_o[CCR_Z], 1'b1);
    alu(OP_DEC_ADJ, 16'h009a, 16'h0000, 8'h00);
    chk(ccr_o[CCR_C], 1'b1);
    alu(OP_DEC_ADJ, 16'h0015, 16'h0000, 8'h20);
    chk(ccr_o[CCR_C], 1'b0);
    alu(OP_DIVIDE, 16'h0100, 16'h0080, 8'h00);
    chk(n_cyc, 16'h000e);
    chk(ccr_o[CCR_N], 1'b1);
    chk(ccr_o[CCR_Z], 1'b0);
    alu(OP_DIVIDE, 16'h0100, 16'h0000, 8'h08);
    chk(ccr_o[CCR_Z], 1'b1);
    chk(ccr_o[CCR_N], 1'b0);
    chk(rd_we_o, 1'b0);
    for (int n = 0; n < 4; n += 3)
    begin
      rq = '0;
      rq.op = OP_REPEAT;
      rq.count = n[7:0];
      go;
      chk(n_cyc, 16'(4 * n + 9));
    end
  endtask

  // cycle ceiling against hangs
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 3000)
    begin
      n_fail++;
      summarize;
    end
  end

  // reset then scenarios
  initial
  begin
    n_fail = 0;
    check_count = 0;
    cyc = 0;
    rstn = 1'b0;
    start_i = 1'b0;
    wake_i = 1'b0;
    req_i = '0;
    rq = '0;
    repeat (3) @(negedge clk);
    rstn = 1'b1;
    t_call_ret;
    t_exc;
    t_reset;
    t_sleep;
    t_flags;
    t_alu;
    summarize;
  end
endmodule // test_cpu_subroutine_ccr_instr
